// >>> logic/mmr_consts.vh
/*
  Constants of the magnetometer readout register block: register
  offsets, bit positions, reset values and bus figures.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef MMR_CONSTS_VH
`define MMR_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define MMR_X_FIELD_LOW        8'h00
`define MMR_X_FIELD_HIGH       8'h01
`define MMR_Y_FIELD_LOW        8'h02
`define MMR_Y_FIELD_HIGH       8'h03
`define MMR_Z_FIELD_LOW        8'h04
`define MMR_Z_FIELD_HIGH       8'h05
`define MMR_TEMPERATURE_RESULT 8'h06
`define MMR_DEVICE_STATUS      8'h07
`define MMR_CONTROL_FIRST      8'h08
`define MMR_CONTROL_SECOND     8'h09
`define MMR_CONTROL_THIRD      8'h0A
`define MMR_MOTION_LIMIT_X     8'h0B
`define MMR_MOTION_LIMIT_Y     8'h0C
`define MMR_MOTION_LIMIT_Z     8'h0D
`define MMR_PART_IDENTIFIER    8'h2F

// ****************************************
// Status bit positions
// ****************************************
`define MMR_ST_FIELD_DONE  0
`define MMR_ST_TEMP_DONE   1
`define MMR_ST_MOTION      2
`define MMR_ST_PUMP_ON     3
`define MMR_ST_OTP_DONE    4

// ****************************************
// Control-first bit positions
// ****************************************
`define MMR_C0_FIELD_MEASURE_TRIGGER 0
`define MMR_C0_TEMP_TRIGGER          1
`define MMR_C0_MOTION_START          2
`define MMR_C0_COIL_SET              3
`define MMR_C0_COIL_RESET            4
`define MMR_C0_REFILL                5
`define MMR_C0_OTP_RELOAD            6
`define MMR_C0_TEST_SELECT           7

// ****************************************
// Control-third interrupt enables
// ****************************************
`define MMR_C2_IEN_FIELD   0
`define MMR_C2_IEN_TEMP    1
`define MMR_C2_IEN_MOTION  2

// ****************************************
// Reset values and bus figures
// ****************************************
`define MMR_STATUS_RESET   8'h00
`define MMR_CONTROL_RESET  8'h00
`define MMR_LIMIT_RESET    8'h00
`define MMR_RESULT_RESET   8'h00
`define MMR_BYTE_BITS      4'h8

`endif

// >>> logic/mmr_flag.v
/*
  Bank of sticky flags, each set by hardware and cleared by a strobe.
  Assumes set and clear strobes are on clk; set beats a clear.
*/
`timescale 1ns/1ps
module mmr_flag #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] set,
  input  wire [WIDTH-1:0] clr,
  output reg  [WIDTH-1:0] q
);

  // ****************************************
  // Set wins so an event in the clear cycle survives
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {WIDTH{1'b0}};
    end else begin
      q <= set | (q & ~clr);
    end
  end

endmodule

// >>> logic/mmr_sync.v
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes the input comes from a pin outside the clk domain.
*/
`timescale 1ns/1ps
module mmr_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire async_in,
  output reg  sync_out
);

  reg stage1;  // First stage, read only by the second

  // ****************************************
  // Two flip-flops, idle high like the bus
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// >>> logic/mmr_top.v
/*
  Magnetometer readout registers behind a two-wire serial slave.
  Assumes the measurement engine, pump and memory loader sit on clk
  and send one-cycle done pulses; bus pins are external and slow.
*/
`timescale 1ns/1ps
`include "mmr_consts.vh"
module mmr_top #(
  parameter [6:0] DEV_ADDR = 7'h30,  // Slave address, plain default
  parameter [7:0] PART_ID  = 8'h5A   // Arbitrary identifier value
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         int_out,
  output reg         int_oe,
  input  wire        field_done,
  input  wire [15:0] x_value,
  input  wire [15:0] y_value,
  input  wire [15:0] z_value,
  input  wire        temp_done,
  input  wire [7:0]  temp_value,
  input  wire        motion_seen,
  input  wire        pump_charged,
  input  wire        otp_loaded,
  output reg         field_measure_start,
  output reg         temp_measure_start,
  output reg         motion_enable,
  output reg         coil_set_start,
  output reg         coil_reset_start,
  output reg         pump_start,
  output reg         otp_reload_start,
  output reg  [7:0]  meas_config,
  output reg  [7:0]  motion_limit_x,
  output reg  [7:0]  motion_limit_y,
  output reg  [7:0]  motion_limit_z
);

  // ****************************************
  // Serial engine states
  // ****************************************
  localparam [3:0] S_IDLE  = 4'h0;  // Waiting for start
  localparam [3:0] S_ADDR  = 4'h1;  // Receiving slave address
  localparam [3:0] S_AACK  = 4'h2;  // Acking the address
  localparam [3:0] S_REG   = 4'h3;  // Receiving register pointer
  localparam [3:0] S_WACK  = 4'h4;  // Acking pointer or data
  localparam [3:0] S_WDATA = 4'h5;  // Receiving write data
  localparam [3:0] S_RDATA = 4'h6;  // Shifting out read data
  localparam [3:0] S_RACK  = 4'h7;  // Sampling master ack
  localparam [3:0] S_RNEXT = 4'h8;  // Master acked, load next

  wire       scl_s;          // Synchronised clock line
  wire       sda_s;          // Synchronised data line
  reg        scl_d;          // Clock line one cycle later
  reg        sda_d;          // Data line one cycle later
  reg  [3:0] state;          // Engine state
  reg  [3:0] bit_cnt;        // Bits of current byte
  reg  [7:0] shreg;          // Byte shift register
  reg  [7:0] ptr;            // Register pointer
  reg        is_read;        // Direction of transfer
  reg        bus_free;       // Both lines seen high
  reg        wr_pulse;       // Register write strobe
  reg  [7:0] wr_addr;        // Register write address
  reg  [7:0] wr_data;        // Register write data
  reg  [7:0] rd_byte;        // Read mux output
  reg  [15:0] x_store;       // X field result
  reg  [15:0] y_store;       // Y field result
  reg  [15:0] z_store;       // Z field result
  reg  [7:0] temp_store;     // Temperature code
  reg  [7:0] ctrl0;          // Held bits of control_first
  reg  [7:0] ctrl2;          // Control_third, low bits enable irq
  wire [4:0] status_q;       // Sticky status bits
  wire [1:0] pend_q;         // Pending field and temp interrupts
  wire       scl_rise;       // Clock line rising edge
  wire       scl_fall;       // Clock line falling edge
  wire       start_cond;     // Data falls while clock high
  wire       stop_cond;      // Data rises while clock high
  wire       wr_status;      // Write to status register
  wire       wr_ctrl0;       // Write to control_first
  wire       fm_cmd;         // Field measurement command
  wire       tm_cmd;         // Temperature measurement command
  wire       pump_cmd;       // Refill command
  wire       otp_cmd;        // Memory reload command
  wire [4:0] st_set;         // Status set strobes
  wire [4:0] st_clr;         // Status clear strobes
  wire [1:0] pend_clr;       // Pending clear strobes

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  mmr_sync u_scl_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (scl_in),
    .sync_out (scl_s)
  );

  mmr_sync u_sda_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (sda_in),
    .sync_out (sda_s)
  );

  // Delayed copies for edges
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    case (ptr)
      `MMR_X_FIELD_LOW:        rd_byte = x_store[7:0];
      `MMR_X_FIELD_HIGH:       rd_byte = x_store[15:8];
      `MMR_Y_FIELD_LOW:        rd_byte = y_store[7:0];
      `MMR_Y_FIELD_HIGH:       rd_byte = y_store[15:8];
      `MMR_Z_FIELD_LOW:        rd_byte = z_store[7:0];
      `MMR_Z_FIELD_HIGH:       rd_byte = z_store[15:8];
      `MMR_TEMPERATURE_RESULT: rd_byte = temp_store;
      `MMR_DEVICE_STATUS:      rd_byte = {3'h0, status_q};
      `MMR_CONTROL_FIRST:      rd_byte = ctrl0;
      `MMR_CONTROL_SECOND:     rd_byte = meas_config;
      `MMR_CONTROL_THIRD:      rd_byte = ctrl2;
      `MMR_MOTION_LIMIT_X:     rd_byte = motion_limit_x;
      `MMR_MOTION_LIMIT_Y:     rd_byte = motion_limit_y;
      `MMR_MOTION_LIMIT_Z:     rd_byte = motion_limit_z;
      `MMR_PART_IDENTIFIER:    rd_byte = PART_ID;
      default:                 rd_byte = 8'h00;  // Unmapped reads zero
    endcase
  end

  // ****************************************
  // Serial slave engine
  // ****************************************
  // Never drives the clock and only pulls data low: slave only.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= S_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      is_read  <= 1'b0;
      bus_free <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      sda_out  <= 1'b0;  // Open drain: enable pulls low
      if (stop_cond) begin
        // Stop ends any transfer and frees the bus
        state    <= S_IDLE;
        sda_oe   <= 1'b0;
        bus_free <= 1'b1;
      end else if (start_cond && (bus_free || state != S_IDLE)) begin
        // Fresh start from idle bus, or repeated start
        state    <= S_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe   <= 1'b0;
        bus_free <= 1'b0;
      end else begin
        // Both lines high while idle counts as a free bus
        if (state == S_IDLE && scl_s && sda_s) begin
          bus_free <= 1'b1;
        end
        case (state)
          S_ADDR, S_REG, S_WDATA: begin
            if (scl_rise) begin
              // Sample on rising clock, data stable while high
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `MMR_BYTE_BITS) begin
              // Ack is driven only after clock went low
              bit_cnt <= 4'h0;
              if (state == S_ADDR) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  is_read <= shreg[0];
                  sda_oe  <= 1'b1;
                  state   <= S_AACK;
                end else begin
                  state <= S_IDLE;
                end
              end else if (state == S_REG) begin
                ptr    <= shreg;
                sda_oe <= 1'b1;
                state  <= S_WACK;
              end else begin
                wr_pulse <= 1'b1;
                wr_addr  <= ptr;
                wr_data  <= shreg;
                ptr      <= ptr + 8'h01;
                sda_oe   <= 1'b1;
                state    <= S_WACK;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              if (is_read) begin
                // Load first byte, drive its top bit
                shreg   <= rd_byte;
                sda_oe  <= ~rd_byte[7];
                bit_cnt <= 4'h1;
                ptr     <= ptr + 8'h01;
                state   <= S_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state  <= S_REG;
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state  <= S_WDATA;
            end
          end
          S_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == `MMR_BYTE_BITS) begin
                sda_oe <= 1'b0;  // Release for master ack
                state  <= S_RACK;
              end else begin
                sda_oe  <= ~shreg[6];
                shreg   <= {shreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            // High means not acked: go idle, off the bus till the next start
            if (scl_rise) begin
              state <= sda_s ? S_IDLE : S_RNEXT;
            end
          end
          S_RNEXT: begin
            if (scl_fall) begin
              shreg   <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              bit_cnt <= 4'h1;
              ptr     <= ptr + 8'h01;
              state   <= S_RDATA;
            end
          end
          default: begin
            state  <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  assign wr_status = wr_pulse && wr_addr == `MMR_DEVICE_STATUS;
  assign wr_ctrl0  = wr_pulse && wr_addr == `MMR_CONTROL_FIRST;
  assign fm_cmd    = wr_ctrl0 && wr_data[`MMR_C0_FIELD_MEASURE_TRIGGER];
  assign tm_cmd    = wr_ctrl0 && wr_data[`MMR_C0_TEMP_TRIGGER];
  assign pump_cmd  = wr_ctrl0 && wr_data[`MMR_C0_REFILL];
  assign otp_cmd   = wr_ctrl0 && wr_data[`MMR_C0_OTP_RELOAD];

  // ****************************************
  // Status flags and pending interrupts
  // ****************************************
  // Status bits follow commands; writing one to them only clears irq,
  // except motion, which is itself the interrupt flag.
  assign st_set = {otp_loaded, pump_cmd, motion_seen, temp_done, field_done};
  assign st_clr = {otp_cmd, pump_charged,
                   wr_status & wr_data[`MMR_ST_MOTION],
                   tm_cmd, fm_cmd};
  assign pend_clr = {wr_status & wr_data[`MMR_ST_TEMP_DONE],
                     wr_status & wr_data[`MMR_ST_FIELD_DONE]};

  mmr_flag #(
    .WIDTH (5)
  ) u_status (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (st_set),
    .clr   (st_clr),
    .q     (status_q)
  );

  mmr_flag #(
    .WIDTH (2)
  ) u_pending (
    .clk   (clk),
    .rst_n (rst_n),
    .set   ({temp_done, field_done}),
    .clr   (pend_clr),
    .q     (pend_q)
  );

  // ****************************************
  // Writable registers and command pulses
  // ****************************************
  // Result registers have no write path at all.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0               <= `MMR_CONTROL_RESET;
      ctrl2               <= `MMR_CONTROL_RESET;
      meas_config         <= `MMR_CONTROL_RESET;
      motion_limit_x      <= `MMR_LIMIT_RESET;
      motion_limit_y      <= `MMR_LIMIT_RESET;
      motion_limit_z      <= `MMR_LIMIT_RESET;
      field_measure_start <= 1'b0;
      temp_measure_start  <= 1'b0;
      coil_set_start      <= 1'b0;
      coil_reset_start    <= 1'b0;
      pump_start          <= 1'b0;
      otp_reload_start    <= 1'b0;
      motion_enable       <= 1'b0;
    end else begin
      field_measure_start <= fm_cmd;
      temp_measure_start  <= tm_cmd;
      coil_set_start      <= wr_ctrl0 && wr_data[`MMR_C0_COIL_SET];
      coil_reset_start    <= wr_ctrl0 && wr_data[`MMR_C0_COIL_RESET];
      pump_start          <= pump_cmd;
      otp_reload_start    <= otp_cmd;
      if (wr_ctrl0) begin
        // Measure and reload triggers self-clear, so bits 0, 1 and 6 are never stored
        ctrl0 <= wr_data & 8'hBC;
      end else if (motion_seen) begin
        ctrl0[`MMR_C0_MOTION_START] <= 1'b0;  // Detector stops on motion
      end
      motion_enable <= wr_ctrl0 ? wr_data[`MMR_C0_MOTION_START]
                                : (ctrl0[`MMR_C0_MOTION_START] & ~motion_seen);
      if (wr_pulse) begin
        case (wr_addr)
          `MMR_CONTROL_SECOND: meas_config    <= wr_data;
          `MMR_CONTROL_THIRD:  ctrl2          <= wr_data;
          `MMR_MOTION_LIMIT_X: motion_limit_x <= wr_data;
          `MMR_MOTION_LIMIT_Y: motion_limit_y <= wr_data;
          `MMR_MOTION_LIMIT_Z: motion_limit_z <= wr_data;
          default: ;  // Control_first handled above; status, read-only or unmapped: ignored here
        endcase
      end
    end
  end

  // ****************************************
  // Result capture
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_store    <= {`MMR_RESULT_RESET, `MMR_RESULT_RESET};
      y_store    <= {`MMR_RESULT_RESET, `MMR_RESULT_RESET};
      z_store    <= {`MMR_RESULT_RESET, `MMR_RESULT_RESET};
      temp_store <= `MMR_RESULT_RESET;
    end else begin
      if (field_done) begin
        x_store <= x_value;
        y_store <= y_value;
        z_store <= z_value;
      end
      if (temp_done) begin
        temp_store <= temp_value;
      end
    end
  end

  // ****************************************
  // Interrupt pin
  // ****************************************
  // Pin floats until some enable is set, then drives active high.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_out <= 1'b0;
      int_oe  <= 1'b0;
    end else begin
      int_oe  <= |ctrl2[2:0];
      int_out <= (pend_q[0] & ctrl2[`MMR_C2_IEN_FIELD])
               | (pend_q[1] & ctrl2[`MMR_C2_IEN_TEMP])
               | (status_q[`MMR_ST_MOTION] & ctrl2[`MMR_C2_IEN_MOTION]);
    end
  end

endmodule

// >>> tb/mmr_checker.sv
/*
  Concurrent checks on the pins of the readout register block.
  Assumes binding to mmr_top; sees its ports only, one clock domain.
*/
`timescale 1ns/1ps
module mmr_checker (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire int_out,
  input wire int_oe,
  input wire field_done,
  input wire temp_done,
  input wire motion_seen,
  input wire motion_enable,
  input wire field_measure_start,
  input wire pump_start
);
  // ****************************************
  // Helpers and defaults
  // ****************************************
  wire evt = field_done | temp_done | motion_seen;  // Any interrupt source
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Properties
  // ****************************************
  // Open drain: the pin is only ever pulled low
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda_out not low");
  // Sync lag means three high samples before the data must hold
  property p_stab; scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe); endproperty
  a_stab: assert property (p_stab) else $error("sda moved in clock high");
  property p_rst; $rose(rst_n) |-> !sda_oe && !int_oe && !int_out; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_ioe; !int_oe |-> !int_out; endproperty
  a_ioe: assert property (p_ioe) else $error("int high while floating");
  property p_irise; $rose(int_out) |-> $past(evt) || $past(evt, 2) || $past(evt, 3); endproperty
  a_irise: assert property (p_irise) else $error("int rose without event");
  property p_mot; motion_seen |-> ##[1:3] !motion_enable; endproperty
  a_mot: assert property (p_mot) else $error("motion start not dropped");
  property p_pump; pump_start |=> !pump_start; endproperty
  a_pump: assert property (p_pump) else $error("pump start too long");
  property p_fms; field_measure_start |=> !field_measure_start; endproperty
  a_fms: assert property (p_fms) else $error("trigger not self cleared");
  property p_fack; field_measure_start |-> ##[0:5] sda_oe; endproperty
  a_fack: assert property (p_fack) else $error("trigger write not acked");
endmodule
bind mmr_top mmr_checker u_chk (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe), .field_done(field_done),
  .temp_done(temp_done), .motion_seen(motion_seen), .motion_enable(motion_enable),
  .field_measure_start(field_measure_start), .pump_start(pump_start));

// >>> tb/mmr_host.sv
/*
  Two-wire bus master model that drives the readout block.
  Assumes the bench resolves SDA with a pull-up and SCL of 800 ns.
*/
`timescale 1ns/1ps
module mmr_host (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  // ****************************************
  // Bus cycles, every move on a falling clk
  // ****************************************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task tk(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Also serves as repeated start
  task start;
    tk(2);
    sda_low = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(2);
    sda_low = 1'b1;
    tk(2);
    scl = 1'b0;
  endtask
  task stop;
    tk(2);
    sda_low = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(2);
    sda_low = 1'b0;
    tk(4);
  endtask
  // Data moves only in the low half, sampled mid high
  task bitx(input b, output r);
    tk(2);
    sda_low = ~b;
    tk(2);
    scl = 1'b1;
    tk(2);
    r = sda;
    tk(2);
    scl = 1'b0;
  endtask
  // Sending all ones releases SDA, so one task reads too
  task xfer(input [7:0] tx, input ack_me, output [7:0] rx, output acked);
    integer i;
    reg     a;
    for (i = 7; i >= 0; i = i - 1) bitx(tx[i], rx[i]);
    bitx(~ack_me, a);
    acked = ~a;
  endtask
endmodule

// >>> tb/mmr_testbench.sv
/*
  Bench: host model, behavioural register model and comparisons.
  Assumes the checker binds itself to the design top.
*/
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Signals and model state
  // ****************************************
  reg         clk, rst_n, fd, td, ms, pc, ol, ak;
  reg  [15:0] xv, yv, zv, rs;
  reg  [7:0]  tv, rx;
  reg  [47:0] f;
  wire        scl, sl, so, oe, io, ie, men;
  wire [7:0]  pv, mc, lx, ly, lz;
  wire [31:0] lims = {lz, ly, lx, mc};
  wire        sda  = (sl | (oe & ~so)) ? 1'b0 : 1'b1;  // Pull-up wins when released
  integer     fail_count, n_checks, pf, pt, i, b, j;
  integer     mdl [0:255];
  integer     cnt [0:7];
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  mmr_top #(.DEV_ADDR(7'h30), .PART_ID(8'hA7)) uut (  // Identifier arbitrary
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe),
    .int_out(io), .int_oe(ie), .field_done(fd), .x_value(xv), .y_value(yv), .z_value(zv),
    .temp_done(td), .temp_value(tv), .motion_seen(ms), .pump_charged(pc), .otp_loaded(ol),
    .field_measure_start(pv[0]), .temp_measure_start(pv[1]), .motion_enable(men),
    .coil_set_start(pv[3]), .coil_reset_start(pv[4]), .pump_start(pv[5]),
    .otp_reload_start(pv[6]), .meas_config(mc), .motion_limit_x(lx),
    .motion_limit_y(ly), .motion_limit_z(lz));
  mmr_host m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sl));
  // Bits 2 and 7 carry no pulse output, so they stay at zero
  assign {pv[7], pv[2]} = 2'h0;
  // Pulse counters per control bit
  always @(posedge clk) for (j = 0; j < 8; j = j + 1) if (pv[j] === 1'b1) cnt[j] = cnt[j] + 1;
  // ****************************************
  // Tasks
  // ****************************************
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [15:0] s, input [15:0] e, input [8*5:1] nm);
    n_checks = n_checks + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("FAIL %0s exp %h seen %h", nm, e, s);
    end
  endtask
  task close_out;
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task adr(input [7:0] v);
    m.xfer(v, 1'b0, rx, ak);
    chk(ak, 1, "ack");
  endtask
  // Interrupt pin against model after the two-cycle latency
  task ichk;
    repeat (4) @(negedge clk);
    chk(io, ((pf & mdl[10]) | (pt & (mdl[10] >> 1)) | ((mdl[7] & mdl[10]) >> 2)) & 1, "int");
    chk(ie, (mdl[10] & 7) != 0, "ioe");
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    m.start;
    adr(8'h60);
    adr(a);
    adr(d);
    m.stop;
    case (a)
      8'h07: begin
        mdl[7] = mdl[7] & ~(d & 4);
        if (d[0]) pf = 0;
        if (d[1]) pt = 0;
      end
      8'h08: begin
        mdl[8] = d & 8'hBC;
        mdl[7] = (mdl[7] & ~(d & 3) & ~((d & 64) >> 2)) | ((d & 32) >> 2);
      end
      8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D: mdl[a] = d;
      default: ;
    endcase
    ichk;
  endtask
  task rd(input [7:0] a, input integer n);
    integer k;
    m.start;
    adr(8'h60);
    adr(a);
    m.start;
    adr(8'h61);
    for (k = 0; k < n; k = k + 1) begin
      m.xfer(8'hFF, k < n - 1, rx, ak);
      chk(rx, mdl[(a + k) & 255], "rdata");
    end
    m.stop;
  endtask
  // One-cycle event pulse from the sensing side
  task ev(input integer k);
    @(negedge clk);
    rs = nx(rs);
    case (k)
      0: begin
        fd = 1'b1;
        {zv, yv, xv} = {rs ^ 16'h5A5A, ~rs, rs};
        f = {zv, yv, xv};
        for (j = 0; j < 6; j = j + 1) mdl[j] = f[8*j+:8];
        mdl[7] = mdl[7] | 1;
        pf = 1;
      end
      1: begin
        td = 1'b1;
        tv = rs[7:0];
        mdl[6] = tv;
        mdl[7] = mdl[7] | 2;
        pt = 1;
      end
      2: begin
        ms = 1'b1;
        mdl[7] = mdl[7] | 4;
        mdl[8] = mdl[8] & ~4;
      end
      3: begin
        pc = 1'b1;
        mdl[7] = mdl[7] & ~8;
      end
      default: begin
        ol = 1'b1;
        mdl[7] = mdl[7] | 16;
      end
    endcase
    @(negedge clk);
    {fd, td, ms, pc, ol} = 5'h00;
    ichk;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {fd, td, ms, pc, ol, ak} = 6'h00;
    {xv, yv, zv, tv, rx} = 64'h0;
    rst_n = 1'b0;
    rs = 16'h0039;
    {fail_count, n_checks, pf, pt} = 128'h0;
    for (i = 0; i < 256; i = i + 1) mdl[i] = 0;
    for (i = 0; i < 8; i = i + 1) cnt[i] = 0;
    mdl[8'h2F] = 8'hA7;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    rd(8'h00, 8);
    rd(8'h0D, 4);
    rd(8'h2F, 1);
    ichk;
    wreg(8'h0A, 8'h07);
    for (i = 0; i < 4; i = i + 1) begin
      rs = nx(rs);
      wreg((i == 0) ? 8'h09 : 8'h0A + i, rs[7:0]);
      chk(lims[8*i+:8], mdl[(i == 0) ? 9 : 10 + i], "limit");
    end
    rd(8'h09, 5);
    ev(0);
    rd(8'h07, 1);
    rd(8'h00, 8);
    rs = nx(rs);
    wreg(8'h00, rs[7:0]);
    wreg(8'h05, rs[15:8]);
    rd(8'h00, 6);
    wreg(8'h07, 8'h01);
    rd(8'h07, 1);
    ev(1);
    rd(8'h06, 2);
    wreg(8'h07, 8'h02);
    for (b = 0; b < 8; b = b + 1) begin
      wreg(8'h08, 8'h01 << b);
      chk(cnt[b], (8'h7B >> b) & 1, "pulse");
      rd(8'h07, 2);
    end
    ev(3);
    ev(4);
    rd(8'h07, 1);
    wreg(8'h08, 8'h04);
    chk(men, 1, "men");
    ev(2);
    chk(men, 0, "men");
    rd(8'h07, 2);
    wreg(8'h07, 8'h04);
    rd(8'h07, 1);
    m.start;
    m.xfer(8'h62, 1'b0, rx, ak);
    chk(ak, 0, "nack");
    m.stop;
    rd(8'h2F, 1);
    close_out;
  end
endmodule
